/* design/cdsc_frame_if.sv */
// Received serial words passed from the frame receiver to the control logic.
`default_nettype none
interface cdsc_frame_if;
	logic        wordValid;
	logic [15:0] word;
	logic        frameActive;

	modport rx (
		output wordValid,
		output word,
		output frameActive
	);
	modport ctl (
		input wordValid,
		input word,
		input frameActive
	);
endinterface
`default_nettype wire

/* design/cdsc_pkg.sv */
// Constants, types and decoding shared by the serial control block.
`default_nettype none
package cdsc_pkg;
	localparam int WORD_BITS = 16;
	localparam logic [4:0] WORD_LAST_BIT = 5'h0F;
	localparam logic [4:0] WORD_BIT_COUNT = 5'h10;

	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 13;
	localparam int RW_BIT = 12;
	localparam int ZERO_HI_BIT = 11;
	localparam int RANGE_MSB = 10;
	localparam int RANGE_LSB = 7;
	localparam int CLEAR_LEVEL_SELECT_BIT = 6;
	localparam int OUTPUT_ENABLE_BIT_BIT = 5;
	localparam int CLEAR_BIT = 4;
	localparam int SENSE_RESISTOR_SELECT_BIT = 3;
	localparam int RESET_BIT = 2;

	localparam logic [15:0] CTRL_WRITABLE_MASK = 16'h07F8;
	localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;

	localparam int REG_ADDR_BITS = 8;
	localparam logic [7:0] REG_CONTROL_OFS = 8'h00;
	localparam logic [7:0] REG_STATUS_OFS = 8'h04;
	localparam logic [7:0] REG_COUNT_OFS = 8'h08;

	localparam logic [4:0] RANGE_CODE_4_20 = 5'h00;
	localparam logic [4:0] RANGE_CODE_0_24 = 5'h02;

	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
	// Link flops reset to the idle levels of clock and select, so no false edge follows reset.
	localparam logic [2:0] RX_SYNC_RESET = 3'h5;
	localparam logic [11:0] PIN_SYNC_RESET = 12'h000;

	typedef enum logic [1:0] {
		RNG_4_20   = 2'b00,
		RNG_0_24   = 2'b01,
		RNG_UNUSED = 2'b10
	} cdsc_range_e;

	typedef enum logic [1:0] {
		MODE_STARTUP  = 2'b00,
		MODE_SOFTWARE = 2'b01,
		MODE_HARDWARE = 2'b10
	} cdsc_mode_e;

	function automatic cdsc_range_e cdscDecodeRange(input logic sense_resistor_select, input logic [3:0] code);
		logic [4:0] full;
		full = {sense_resistor_select, code};
		if (full == RANGE_CODE_4_20) begin
			return RNG_4_20;
		end else if (full == RANGE_CODE_0_24) begin
			return RNG_0_24;
		end
		return RNG_UNUSED;
	endfunction
endpackage
`default_nettype wire

/* design/cdsc_serial_rx.sv */
// Serial frame receiver: synchronises the link pins and assembles 16-bit words.
`default_nettype none
module cdsc_serial_rx
	import cdsc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   serialClk,
	input  wire logic   serialData,
	input  wire logic   frameSelectN,
	cdsc_frame_if.rx    frame
);
	logic [2:0]  syncA_q;
	logic [2:0]  syncB_q;
	logic        sclkPrev_q;
	logic [4:0]  bitCount_q;
	logic [15:0] shift_q;
	logic [15:0] word_q;
	logic        wordValid_q;

	wire logic        sclkS    = syncB_q[2];
	wire logic        dataS    = syncB_q[1];
	wire logic        selected = ~syncB_q[0];
	wire logic        sclkFall = sclkPrev_q & ~sclkS;
	wire logic        takeBit  = selected & sclkFall & (bitCount_q < WORD_BIT_COUNT);
	wire logic [15:0] shiftNext = {shift_q[14:0], dataS};

	always_ff @(posedge clk) begin
		if (reset) begin
			syncA_q    <= RX_SYNC_RESET;
			syncB_q    <= RX_SYNC_RESET;
			sclkPrev_q <= 1'b1;
		end else begin
			syncA_q    <= {serialClk, serialData, frameSelectN};
			syncB_q    <= syncA_q;
			sclkPrev_q <= sclkS;
		end
	end

	// Bits beyond the sixteenth are dropped until the select is released.
	always_ff @(posedge clk) begin
		if (reset || !selected) begin
			bitCount_q  <= 5'h00;
			shift_q     <= 16'h0000;
			wordValid_q <= 1'b0;
		end else begin
			wordValid_q <= takeBit && (bitCount_q == WORD_LAST_BIT);
			if (takeBit) begin
				shift_q    <= shiftNext;
				bitCount_q <= bitCount_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			word_q <= 16'h0000;
		end else if (takeBit && (bitCount_q == WORD_LAST_BIT)) begin
			word_q <= shiftNext;
		end
	end

	assign frame.wordValid   = wordValid_q;
	assign frame.word        = word_q;
	assign frame.frameActive = selected;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_WORD_AFTER_SIXTEEN:
	assert property (wordValid_q |-> $past(bitCount_q) == WORD_LAST_BIT && bitCount_q == WORD_BIT_COUNT)
		else $error("word delivered before sixteen bits");
	AST_LAST_BIT_IS_LSB:
	assert property (wordValid_q |-> word_q[0] == $past(dataS) && word_q[15:1] == $past(shift_q[14:0]))
		else $error("word not assembled MSB first");
	AST_SHIFT_ON_FALL_ONLY:
	assert property ($past(selected) && selected && $changed(bitCount_q) |-> $past(sclkFall))
		else $error("bit taken without a falling serial clock edge");
endmodule
`default_nettype wire

/* design/cdsc_top.sv */
// Serial control and mode logic of a single-channel current-output driver.
`default_nettype none
module cdsc_top
	import cdsc_pkg::*;
#(
	parameter int COUNT_WIDTH = 8
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        serialClk,
	input  wire logic        serialData,
	input  wire logic        frameSelectN,
	input  wire logic        controlModeSelect,
	input  wire logic        resetPinN,
	input  wire logic        clearPin,
	input  wire logic        clearLevelPin,
	input  wire logic        outputEnablePin,
	input  wire logic [3:0]  rangePins,
	input  wire logic [2:0]  boardAddressPins,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic [31:0]      regRdData,
	output logic             outputDriveEn,
	output logic             outputTristate,
	output logic             clearForce,
	output logic             clearLevel,
	output logic [1:0]       rangeSelect,
	output logic [3:0]       rangeCode,
	output logic             senseResistorSel,
	output logic             softwareMode
);
	cdsc_frame_if frame ();

	cdsc_serial_rx u_rx (
		.clk          (clk),
		.reset        (reset),
		.serialClk    (serialClk),
		.serialData   (serialData),
		.frameSelectN (frameSelectN),
		.frame        (frame)
	);

	logic [11:0]            pinA_q;
	logic [11:0]            pinB_q;
	cdsc_mode_e             mode_q;
	cdsc_mode_e             mode_d;
	logic [1:0]             settle_q;
	logic [15:0]            ctrl_q;
	logic [15:0]            ctrl_d;
	logic [COUNT_WIDTH-1:0] acceptCount_q;
	logic [COUNT_WIDTH-1:0] rejectCount_q;
	logic [31:0]            rdData_q;
	logic                   driveEn_q;
	logic                   clear_q;
	logic                   clearLevel_q;
	cdsc_range_e            range_q;
	logic [3:0]             rangeCode_q;
	logic                   sense_q;

	// Every strap and control pin crosses two flip-flops before use.
	wire logic       modePinS      = pinB_q[11];
	wire logic       resetPinNS    = pinB_q[10];
	wire logic       clearPinS     = pinB_q[9];
	wire logic       clearLevelS   = pinB_q[8];
	wire logic       enablePinS    = pinB_q[7];
	wire logic [3:0] rangePinsS    = pinB_q[6:3];
	wire logic [2:0] boardAddrS    = pinB_q[2:0];

	wire logic swMode = (mode_q == MODE_SOFTWARE);
	wire logic hwMode = (mode_q == MODE_HARDWARE);

	wire logic        swReset     = swMode & ~resetPinNS;
	wire logic        addrMatch   = (frame.word[ADDR_MSB:ADDR_LSB] == boardAddrS);
	wire logic        frameIsRead = frame.word[RW_BIT];
	wire logic        frameAccept = swMode & frame.wordValid & addrMatch & ~frameIsRead;
	wire logic        frameReject = swMode & frame.wordValid & ~frameAccept;
	wire logic        ctrlSel     = (regAddr == REG_CONTROL_OFS);
	wire logic        statusSel   = (regAddr == REG_STATUS_OFS);
	wire logic        countSel    = (regAddr == REG_COUNT_OFS);
	wire logic        localWrite  = swMode & regWrite & ctrlSel;
	wire logic [15:0] newWord     = localWrite ? regWrData[15:0] : frame.word;
	wire logic        load        = localWrite | frameAccept;
	wire logic        resetCmd    = load & newWord[RESET_BIT];

	wire cdsc_range_e swRange = cdscDecodeRange(ctrl_q[SENSE_RESISTOR_SELECT_BIT], ctrl_q[RANGE_MSB:RANGE_LSB]);
	wire cdsc_range_e hwRange = cdscDecodeRange(1'b0, rangePinsS);

	always_ff @(posedge clk) begin
		if (reset) begin
			pinA_q <= PIN_SYNC_RESET;
			pinB_q <= PIN_SYNC_RESET;
		end else begin
			pinA_q <= {controlModeSelect, resetPinN, clearPin, clearLevelPin,
				outputEnablePin, rangePins, boardAddressPins};
			pinB_q <= pinA_q;
		end
	end

	// The strap is read only once the synchroniser holds a real pin level.
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			MODE_STARTUP: begin
				if (settle_q == STRAP_SETTLE_CYCLES) begin
					mode_d = modePinS ? MODE_HARDWARE : MODE_SOFTWARE;
				end
			end
			MODE_SOFTWARE: mode_d = MODE_SOFTWARE;
			MODE_HARDWARE: mode_d = MODE_HARDWARE;
			default:       mode_d = MODE_STARTUP;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_q   <= MODE_STARTUP;
			settle_q <= 2'h0;
		end else begin
			mode_q <= mode_d;
			if (settle_q != STRAP_SETTLE_CYCLES) begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	// A reset command clears the whole image, reset bit included, so it reads back zero.
	always_comb begin
		ctrl_d = ctrl_q;
		if (swReset || resetCmd) begin
			ctrl_d = CTRL_RESET_VALUE;
		end else if (load) begin
			ctrl_d = newWord & CTRL_WRITABLE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET_VALUE;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			acceptCount_q <= '0;
			rejectCount_q <= '0;
		end else begin
			if (frameAccept) begin
				acceptCount_q <= acceptCount_q + 1'b1;
			end
			if (frameReject) begin
				rejectCount_q <= rejectCount_q + 1'b1;
			end
		end
	end

	// Output stage: software mode follows the control image and the clear pin, hardware mode the pins with sense held low.
	always_ff @(posedge clk) begin
		if (reset || mode_q == MODE_STARTUP) begin
			driveEn_q    <= 1'b0;
			clear_q      <= 1'b0;
			clearLevel_q <= 1'b0;
			range_q      <= RNG_4_20;
			rangeCode_q  <= 4'h0;
			sense_q      <= 1'b0;
		end else if (swMode) begin
			driveEn_q    <= ctrl_q[OUTPUT_ENABLE_BIT_BIT];
			clear_q      <= ctrl_q[OUTPUT_ENABLE_BIT_BIT] & (clearPinS | ctrl_q[CLEAR_BIT]);
			clearLevel_q <= ctrl_q[CLEAR_LEVEL_SELECT_BIT];
			range_q      <= swRange;
			rangeCode_q  <= ctrl_q[RANGE_MSB:RANGE_LSB];
			sense_q      <= ctrl_q[SENSE_RESISTOR_SELECT_BIT];
		end else begin
			driveEn_q    <= enablePinS;
			clear_q      <= enablePinS & clearPinS;
			clearLevel_q <= clearLevelS;
			range_q      <= hwRange;
			rangeCode_q  <= rangePinsS;
			sense_q      <= 1'b0;
		end
	end

	wire logic [31:0] statusWord = {20'h00000, rangeCode_q, range_q, clearPinS, ~resetPinNS,
		driveEn_q, frame.frameActive, hwMode, swMode};
	wire logic [31:0] countWord = {{(32 - 2 * COUNT_WIDTH){1'b0}}, rejectCount_q, acceptCount_q};
	wire logic [31:0] readMux = ctrlSel ? {16'h0000, ctrl_q} :
		statusSel ? statusWord :
		countSel ? countWord : 32'h00000000;

	always_ff @(posedge clk) begin
		if (reset) begin
			rdData_q <= 32'h00000000;
		end else if (regRead) begin
			rdData_q <= readMux;
		end else begin
			rdData_q <= 32'h00000000;
		end
	end

	assign regRdData        = rdData_q;
	assign outputDriveEn    = driveEn_q;
	assign outputTristate   = ~driveEn_q;
	assign clearForce       = clear_q;
	assign clearLevel       = clearLevel_q;
	assign rangeSelect      = range_q;
	assign rangeCode        = rangeCode_q;
	assign senseResistorSel = sense_q;
	assign softwareMode     = swMode;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence resetPinHeld;
		(swMode && !resetPinNS)[*3];
	endsequence

	sequence foreignFrame;
		frame.wordValid && swMode && !addrMatch && !localWrite && !swReset;
	endsequence

	AST_STRAP_SELECTS_MODE:
	assert property (mode_q == MODE_STARTUP && settle_q == STRAP_SETTLE_CYCLES |=>
		mode_q == ($past(modePinS) ? MODE_HARDWARE : MODE_SOFTWARE))
		else $error("mode not taken from strap");
	AST_STARTUP_DISABLED:
	assert property (mode_q == MODE_STARTUP |=> !outputDriveEn && outputTristate)
		else $error("output enabled before mode known");
	AST_RESET_PIN_CLEARS:
	assert property (swReset |=> ctrl_q == CTRL_RESET_VALUE ##1 !outputDriveEn)
		else $error("reset pin did not restore power-on state");
	AST_RESET_PIN_LEVEL:
	assert property (resetPinHeld |-> ctrl_q == CTRL_RESET_VALUE ##1 !outputDriveEn)
		else $error("block left reset while pin held low");
	AST_RESET_BIT_SELF_CLEARS:
	assert property (resetCmd && swMode |=> !ctrl_q[RESET_BIT] && ctrl_q == CTRL_RESET_VALUE)
		else $error("reset bit did not clear itself");
	AST_HW_NO_RESET:
	assert property (hwMode && enablePinS && !resetPinNS |=> outputDriveEn)
		else $error("hardware mode reacted to reset pin");
	AST_DISABLED_TRISTATE:
	assert property (swMode && !ctrl_q[OUTPUT_ENABLE_BIT_BIT] |=> outputTristate && !clearForce)
		else $error("disabled output not tristated");
	AST_CLEAR_WHILE_ENABLED:
	assert property (swMode && ctrl_q[OUTPUT_ENABLE_BIT_BIT] && clearPinS |=> clearForce && outputDriveEn)
		else $error("clear pin not forcing clear state");
	AST_RANGE_0_24:
	assert property (swMode && {ctrl_q[SENSE_RESISTOR_SELECT_BIT], ctrl_q[RANGE_MSB:RANGE_LSB]} == RANGE_CODE_0_24
		|=> rangeSelect == RNG_0_24)
		else $error("range code 00010 not decoded as 0-24 mA");
	AST_FRAME_LOADS:
	assert property (frameAccept && !localWrite && !swReset && !frame.word[RESET_BIT] |=>
		ctrl_q == ($past(frame.word) & CTRL_WRITABLE_MASK))
		else $error("matching frame not loaded");
	AST_FOREIGN_IGNORED:
	assert property (foreignFrame |=> $stable(ctrl_q))
		else $error("foreign frame changed control state");
endmodule
`default_nettype wire

/* testbench/cdsc_host_model.sv */
// Host serial master model that shifts control words into the block.
`default_nettype none
module cdsc_host_model (
	input  wire logic clk,
	output var logic  serialClk,
	output var logic  serialData,
	output var logic  frameSelectN
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		serialClk = 1'b1;
		serialData = 1'b0;
		frameSelectN = 1'b1;
	end

	// Four system cycles per phase give an 800 ns link period, well below 50 MHz.
	task automatic halfPeriod();
		repeat (4) @(posedge clk);
	endtask

	// The link clock stands still between frames; a short count sends a partial frame.
	task automatic sendFrame(input logic [15:0] w, input int n);
		logic [15:0] s;
		s = w & 16'hF7FC;
		@(posedge clk);
		frameSelectN <= 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			serialData <= s[i];
			halfPeriod();
			serialClk <= 1'b0;
			halfPeriod();
			serialClk <= 1'b1;
		end
		halfPeriod();
		frameSelectN <= 1'b1;
		// A released data line must not keep showing the last bit.
		serialData <= ~serialData;
	endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking testbench for the serial control block.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        controlModeSelect = 1'b0;
	logic        resetPinN = 1'b1;
	logic        clearPin = 1'b0;
	logic        clearLevelPin = 1'b0;
	logic        outputEnablePin = 1'b0;
	logic [3:0]  rangePins = 4'h0;
	logic [2:0]  boardAddressPins = 3'h5;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	wire  logic  serialClk;
	wire  logic  serialData;
	wire  logic  frameSelectN;
	logic [31:0] regRdData;
	logic        outputDriveEn;
	logic        outputTristate;
	logic        clearForce;
	logic        clearLevel;
	logic [1:0]  rangeSelect;
	logic [3:0]  rangeCode;
	logic        senseResistorSel;
	logic        softwareMode;
	int          fails = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [31:0] rd;

	localparam logic [4:0] EN = 5'h08;
	localparam logic [4:0] CL = 5'h10;
	localparam logic [4:0] RST = 5'h01;

	cdsc_top #(.COUNT_WIDTH(8)) cdsc_top_inst (
		.clk(clk), .reset(reset), .serialClk(serialClk), .serialData(serialData),
		.frameSelectN(frameSelectN), .controlModeSelect(controlModeSelect),
		.resetPinN(resetPinN), .clearPin(clearPin), .clearLevelPin(clearLevelPin),
		.outputEnablePin(outputEnablePin), .rangePins(rangePins),
		.boardAddressPins(boardAddressPins), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.outputDriveEn(outputDriveEn), .outputTristate(outputTristate),
		.clearForce(clearForce), .clearLevel(clearLevel), .rangeSelect(rangeSelect),
		.rangeCode(rangeCode), .senseResistorSel(senseResistorSel),
		.softwareMode(softwareMode)
	);

	cdsc_host_model cdsc_host_model_inst (
		.clk(clk), .serialClk(serialClk), .serialData(serialData),
		.frameSelectN(frameSelectN)
	);

	always #50 clk = ~clk;

	task automatic final_report();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			fails++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic outs(input logic en, input logic [1:0] rs);
		chk("outputDriveEn", {31'h0, en}, {31'h0, outputDriveEn});
		chk("outputTristate", {31'h0, ~en}, {31'h0, outputTristate});
		chk("rangeSelect", {30'h0, rs}, {30'h0, rangeSelect});
		chk("senseResistorSel", 32'h0, {31'h0, senseResistorSel});
	endtask

	function automatic logic [15:0] mk(input logic [2:0] a, input logic [3:0] r,
		input logic [4:0] f);
		return {a, 2'b00, r, f, 2'b00};
	endfunction

	task automatic send(input logic [15:0] w, input int n);
		cdsc_host_model_inst.sendFrame(w, n);
		wt(8);
	endtask

	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input logic [7:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		rd = regRdData;
	endtask

	task automatic doRst(input logic m);
		@(posedge clk);
		controlModeSelect <= m;
		reset <= 1'b1;
		wt(4);
		reset <= 1'b0;
		wt(8);
	endtask

	task automatic tPowerOn();
		doRst(1'b0);
		outs(1'b0, 2'b00);
		chk("softwareMode", 32'h1, {31'h0, softwareMode});
		regRd(8'h00);
		chk("control", 32'h0, rd);
	endtask

	task automatic tFrames();
		send(mk(3'h5, 4'h2, EN), 16);
		outs(1'b1, 2'b01);
		chk("rangeCode", 32'h2, {28'h0, rangeCode});
		regRd(8'h00);
		chk("control", 32'h120, rd);
		// Range changes only with the output disabled first.
		send(mk(3'h5, 4'h2, 5'h00), 16);
		outs(1'b0, 2'b01);
		send(mk(3'h5, 4'h0, EN), 16);
		outs(1'b1, 2'b00);
	endtask

	task automatic tIgnored();
		for (int a = 0; a < 8; a++) begin
			if (a != 5) begin
				send(mk(a[2:0], 4'h2, 5'h00), 16);
			end
		end
		outs(1'b1, 2'b00);
		send(mk(3'h5, 4'h2, 5'h00), 10);
		outs(1'b1, 2'b00);
		send(mk(3'h5, 4'h2, 5'h00) | 16'h1000, 16);
		outs(1'b1, 2'b00);
		regRd(8'h08);
		chk("count", 32'h0000_0803, rd);
	endtask

	task automatic tClear();
		@(posedge clk);
		clearPin <= 1'b1;
		send(mk(3'h5, 4'h0, EN | CL), 16);
		chk("clearForce", 32'h1, {31'h0, clearForce});
		chk("clearLevel", 32'h1, {31'h0, clearLevel});
		@(posedge clk);
		clearPin <= 1'b0;
		wt(8);
		chk("clearForce", 32'h0, {31'h0, clearForce});
	endtask

	task automatic tResets();
		send(mk(3'h5, 4'h2, EN | RST), 16);
		outs(1'b0, 2'b00);
		regRd(8'h00);
		chk("control", 32'h0, rd);
		regWr(8'h00, 32'h0000_0120);
		regRd(8'h10);
		chk("unmapped", 32'h0, rd);
		outs(1'b1, 2'b01);
		@(posedge clk);
		resetPinN <= 1'b0;
		wt(8);
		outs(1'b0, 2'b00);
		regRd(8'h04);
		chk("status", 32'h0000_0011, rd);
		send(mk(3'h5, 4'h2, EN), 16);
		outs(1'b0, 2'b00);
		@(posedge clk);
		resetPinN <= 1'b1;
		wt(8);
		send(mk(3'h5, 4'h2, EN), 16);
		outs(1'b1, 2'b01);
	endtask

	task automatic tHardware();
		@(posedge clk);
		rangePins <= 4'h2;
		outputEnablePin <= 1'b1;
		clearLevelPin <= 1'b1;
		doRst(1'b1);
		chk("softwareMode", 32'h0, {31'h0, softwareMode});
		outs(1'b1, 2'b01);
		chk("clearLevel", 32'h1, {31'h0, clearLevel});
		regRd(8'h04);
		chk("status", 32'h0000_024A, rd);
		regWr(8'h00, 32'h0000_0020);
		regRd(8'h00);
		chk("control", 32'h0, rd);
		@(posedge clk);
		resetPinN <= 1'b0;
		send(mk(3'h5, 4'h0, 5'h00), 16);
		outs(1'b1, 2'b01);
		@(posedge clk);
		outputEnablePin <= 1'b0;
		resetPinN <= 1'b1;
		wt(8);
		outs(1'b0, 2'b01);
	endtask

	initial begin
		tPowerOn();
		tFrames();
		tIgnored();
		tClear();
		tResets();
		tHardware();
		final_report();
	end
endmodule
`default_nettype wire
